// ---- verilog/tsc_pkg.sv ----
// Shared constants and carrier type of the timer status block
package tsc_pkg;

  // ==========================================================
  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] TSC_OFS_CAP_ONE_HI  = 8'h10;
  localparam logic [7:0] TSC_OFS_CAP_ONE_LO  = 8'h11;
  localparam logic [7:0] TSC_OFS_CMP_ONE_HI  = 8'h12;
  localparam logic [7:0] TSC_OFS_CMP_ONE_LO  = 8'h13;
  localparam logic [7:0] TSC_OFS_CAP_TWO_HI  = 8'h14;
  localparam logic [7:0] TSC_OFS_CAP_TWO_LO  = 8'h15;
  localparam logic [7:0] TSC_OFS_CMP_TWO_HI  = 8'h16;
  localparam logic [7:0] TSC_OFS_CMP_TWO_LO  = 8'h17;
  localparam logic [7:0] TSC_OFS_COUNT_HI    = 8'h18;
  localparam logic [7:0] TSC_OFS_COUNT_LO    = 8'h19;
  localparam logic [7:0] TSC_OFS_ALT_HI      = 8'h1A;
  localparam logic [7:0] TSC_OFS_ALT_LO      = 8'h1B;
  localparam logic [7:0] TSC_OFS_CONTROL     = 8'h1C;
  localparam logic [7:0] TSC_OFS_EDGE        = 8'h1D;
  localparam logic [7:0] TSC_OFS_TIMER_FLAGS = 8'h1E;

  // ==========================================================
  // Field positions of timer_flags
  localparam int TSC_BIT_CAPTURE_ONE_FLAG  = 7;
  localparam int TSC_BIT_CAPTURE_TWO_FLAG  = 6;
  localparam int TSC_BIT_COMPARE_ONE_FLAG  = 5;
  localparam int TSC_BIT_OVERFLOW_FLAG     = 4;
  localparam int TSC_BIT_COMPARE_TWO_FLAG  = 3;
  localparam int TSC_BIT_COMPARE_ONE_INPUT = 2;
  localparam int TSC_BIT_COMPARE_TWO_INPUT = 1;

  // Field positions of the control register
  localparam int TSC_BIT_CAPTURE_ONE_IRQ_ENABLE = 7;
  localparam int TSC_BIT_CAPTURE_TWO_IRQ_ENABLE = 6;
  localparam int TSC_BIT_COMPARE_ONE_IRQ_ENABLE = 5;
  localparam int TSC_BIT_OVERFLOW_IRQ_ENABLE    = 4;
  localparam int TSC_BIT_COMPARE_TWO_IRQ_ENABLE = 3;
  localparam int TSC_BIT_TIMER_SHUTOFF          = 0;

  // Field positions of the edge register (1 = rising edge)
  localparam int TSC_BIT_EDGE_ONE = 1;
  localparam int TSC_BIT_EDGE_TWO = 0;

  // ==========================================================
  // Flag vector index order
  localparam int TSC_FLAG_CAP_ONE = 0;
  localparam int TSC_FLAG_CAP_TWO = 1;
  localparam int TSC_FLAG_CMP_ONE = 2;
  localparam int TSC_FLAG_OVF     = 3;
  localparam int TSC_FLAG_CMP_TWO = 4;
  localparam int TSC_NUM_FLAGS    = 5;

  // ==========================================================
  // Reset values and timing counts
  localparam logic [15:0] TSC_COUNT_RESET    = 16'hFFFC;
  localparam logic [15:0] TSC_COUNT_ALL_ONES = 16'hFFFF;
  localparam logic [7:0]  TSC_CONTROL_RESET  = 8'h00;
  localparam logic [7:0]  TSC_EDGE_RESET     = 8'h00;
  localparam logic [15:0] TSC_COMPARE_RESET  = 16'h0000;
  localparam logic [7:0]  TSC_PRESCALE       = 8'h04;

  // ==========================================================
  // Register port carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tsc_bus_req_t;

endpackage

// ---- verilog/tsc_flag.sv ----
// One status flag with its two-step arm and clear sequence
`timescale 1ns/1ps
module tsc_flag (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Events
  input  wire logic set,
  input  wire logic status_access,
  input  wire logic clear_access,
  // State
  output logic      flag
);

  typedef struct packed {
    logic flag;
    logic armed;
  } tsc_flag_state_t;

  tsc_flag_state_t st;
  tsc_flag_state_t next_st;

  always_comb begin
    next_st = st;
    if (status_access) begin
      next_st.armed = st.flag;
    end
    if (clear_access && st.armed) begin
      next_st.flag  = 1'b0;
      next_st.armed = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (set) begin
      next_st.flag = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

endmodule

// ---- verilog/tsc_capture.sv ----
// One input capture channel: edge detect, stop-mode arming, latch
`timescale 1ns/1ps
module tsc_capture (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Pin and configuration
  input  wire logic        pin,
  input  wire logic        edge_rising,
  input  wire logic        stop_mode,
  input  wire logic        inhibit,
  input  wire logic [15:0] count,
  // Results
  output logic [15:0]      value,
  output logic             event_pulse
);

  typedef struct packed {
    logic        pin_q;
    logic        stop_q;
    logic        armed;
    logic        event_pulse;
    logic [15:0] value;
  } tsc_cap_state_t;

  tsc_cap_state_t st;
  tsc_cap_state_t next_st;
  logic           hit;

  always_comb begin
    next_st             = st;
    next_st.pin_q       = pin;
    next_st.stop_q      = stop_mode;
    next_st.event_pulse = 1'b0;
    hit = edge_rising ? (pin && !st.pin_q) : (!pin && st.pin_q);
    if (stop_mode) begin
      // Only the first edge in stop is kept; no flag yet
      if (hit && !st.armed) begin
        next_st.armed = 1'b1;
        next_st.value = count;
      end
    end else if (st.stop_q && st.armed) begin
      next_st.armed       = 1'b0;
      next_st.event_pulse = 1'b1;
    end else if (hit && !inhibit) begin
      next_st.value       = count;
      next_st.event_pulse = 1'b1;
    end
  end

  // Reset drops any armed edge and its data
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign value       = st.value;
  assign event_pulse = st.event_pulse;

endmodule

// ---- verilog/tsc_timer_status.sv ----
// Timer status flags, free-running counter and low-power behaviour
`timescale 1ns/1ps
module tsc_timer_status #(
  parameter logic [7:0] PRESCALE = tsc_pkg::TSC_PRESCALE
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Register port
  input  wire tsc_pkg::tsc_bus_req_t bus_req,
  output logic [7:0]                rdata,
  // Capture pins
  input  wire logic                 capture_input_pin_one,
  input  wire logic                 capture_input_pin_two,
  // Processor power state
  input  wire logic                 wait_mode,
  input  wire logic                 stop_mode,
  input  wire logic                 irq_enable,
  // Requests
  output logic                      timer_irq,
  output logic                      wait_wake
);

  import tsc_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  pre;
    logic [7:0]  control;
    logic [7:0]  edges;
    logic [15:0] cmp_one;
    logic [15:0] cmp_two;
    logic        si_one;
    logic        si_two;
    logic [1:0]  cap_inhibit;
    logic [7:0]  rdata;
  } tsc_core_state_t;

  tsc_core_state_t            st;
  tsc_core_state_t            next_st;
  logic [15:0]                count_inc;
  logic                       tick;
  logic                       running;
  logic                       match_one;
  logic                       match_two;
  logic                       ovf_event;
  logic                       status_access;
  logic [TSC_NUM_FLAGS-1:0]   set_vec;
  logic [TSC_NUM_FLAGS-1:0]   clear_vec;
  logic [TSC_NUM_FLAGS-1:0]   flags;
  logic [TSC_NUM_FLAGS-1:0]   enables;
  logic [15:0]                cap_one_value;
  logic [15:0]                cap_two_value;
  logic                       cap_one_event;
  logic                       cap_two_event;
  logic [7:0]                 flags_byte;

  // ==========================================================
  // Address decode helper
  function automatic logic hits(input tsc_bus_req_t req, input logic [7:0] ofs);
    hits = (req.rd || req.wr) && (req.addr == ofs);
  endfunction

  // ==========================================================
  // Capture channels
  tsc_capture u_cap_one (
    .clk         (clk),
    .nrst        (nrst),
    .pin         (capture_input_pin_one),
    .edge_rising (st.edges[TSC_BIT_EDGE_ONE]),
    .stop_mode   (stop_mode),
    .inhibit     (st.cap_inhibit[0]),
    .count       (st.count),
    .value       (cap_one_value),
    .event_pulse (cap_one_event)
  );

  tsc_capture u_cap_two (
    .clk         (clk),
    .nrst        (nrst),
    .pin         (capture_input_pin_two),
    .edge_rising (st.edges[TSC_BIT_EDGE_TWO]),
    .stop_mode   (stop_mode),
    .inhibit     (st.cap_inhibit[1]),
    .count       (st.count),
    .value       (cap_two_value),
    .event_pulse (cap_two_event)
  );

  // ==========================================================
  // Flags
  assign status_access = hits(bus_req, TSC_OFS_TIMER_FLAGS);

  assign set_vec[TSC_FLAG_CAP_ONE] = cap_one_event;
  assign set_vec[TSC_FLAG_CAP_TWO] = cap_two_event;
  assign set_vec[TSC_FLAG_CMP_ONE] = match_one;
  assign set_vec[TSC_FLAG_OVF]     = ovf_event;
  assign set_vec[TSC_FLAG_CMP_TWO] = match_two;

  assign clear_vec[TSC_FLAG_CAP_ONE] = hits(bus_req, TSC_OFS_CAP_ONE_LO);
  assign clear_vec[TSC_FLAG_CAP_TWO] = hits(bus_req, TSC_OFS_CAP_TWO_LO);
  assign clear_vec[TSC_FLAG_CMP_ONE] = hits(bus_req, TSC_OFS_CMP_ONE_LO);
  assign clear_vec[TSC_FLAG_CMP_TWO] = hits(bus_req, TSC_OFS_CMP_TWO_LO);
  // Only the true counter low byte; the alternate copy is left out
  assign clear_vec[TSC_FLAG_OVF] =
    bus_req.rd && (bus_req.addr == TSC_OFS_COUNT_LO);

  genvar gi;
  generate
    for (gi = 0; gi < TSC_NUM_FLAGS; gi++) begin : g_flag
      tsc_flag u_flag (
        .clk           (clk),
        .nrst          (nrst),
        .set           (set_vec[gi]),
        .status_access (status_access),
        .clear_access  (clear_vec[gi]),
        .flag          (flags[gi])
      );
    end
  endgenerate

  assign flags_byte = {flags[TSC_FLAG_CAP_ONE],
                       flags[TSC_FLAG_CAP_TWO],
                       flags[TSC_FLAG_CMP_ONE],
                       flags[TSC_FLAG_OVF],
                       flags[TSC_FLAG_CMP_TWO],
                       st.si_one,
                       st.si_two,
                       1'b0};

  // ==========================================================
  // Interrupt request and wake
  assign enables[TSC_FLAG_CAP_ONE] = st.control[TSC_BIT_CAPTURE_ONE_IRQ_ENABLE];
  assign enables[TSC_FLAG_CAP_TWO] = st.control[TSC_BIT_CAPTURE_TWO_IRQ_ENABLE];
  assign enables[TSC_FLAG_CMP_ONE] = st.control[TSC_BIT_COMPARE_ONE_IRQ_ENABLE];
  assign enables[TSC_FLAG_OVF]     = st.control[TSC_BIT_OVERFLOW_IRQ_ENABLE];
  assign enables[TSC_FLAG_CMP_TWO] = st.control[TSC_BIT_COMPARE_TWO_IRQ_ENABLE];

  assign timer_irq = |(flags & enables);
  assign wait_wake = timer_irq && irq_enable && wait_mode;

  // ==========================================================
  // Counter, compares, register writes and read data
  always_comb begin
    next_st   = st;
    tick      = 1'b0;
    // Wait mode does not enter here: the counter keeps going
    running   = !stop_mode && !st.control[TSC_BIT_TIMER_SHUTOFF];
    count_inc = st.count + 16'h0001;
    if (running) begin
      if (st.pre >= PRESCALE - 8'h01) begin
        next_st.pre = 8'h00;
        tick        = 1'b1;
      end else begin
        next_st.pre = st.pre + 8'h01;
      end
    end
    if (tick) begin
      next_st.count = count_inc;
    end
    ovf_event = tick && (st.count == TSC_COUNT_ALL_ONES);
    match_one = tick && (count_inc == st.cmp_one);
    match_two = tick && (count_inc == st.cmp_two);
    if (match_one) begin
      next_st.si_one = capture_input_pin_one;
    end
    if (match_two) begin
      next_st.si_two = capture_input_pin_two;
    end

    // Writes; timer_flags and read-only bytes store nothing
    if (bus_req.wr) begin
      if (bus_req.addr == TSC_OFS_CONTROL) begin
        next_st.control = bus_req.wdata;
      end else if (bus_req.addr == TSC_OFS_EDGE) begin
        next_st.edges = bus_req.wdata;
      end else if (bus_req.addr == TSC_OFS_CMP_ONE_HI) begin
        next_st.cmp_one[15:8] = bus_req.wdata;
      end else if (bus_req.addr == TSC_OFS_CMP_ONE_LO) begin
        next_st.cmp_one[7:0] = bus_req.wdata;
      end else if (bus_req.addr == TSC_OFS_CMP_TWO_HI) begin
        next_st.cmp_two[15:8] = bus_req.wdata;
      end else if (bus_req.addr == TSC_OFS_CMP_TWO_LO) begin
        next_st.cmp_two[7:0] = bus_req.wdata;
      end
    end

    // High-byte read freezes the capture outside stop until its low byte is read
    if (bus_req.rd) begin
      if (bus_req.addr == TSC_OFS_CAP_ONE_HI) begin
        next_st.cap_inhibit[0] = 1'b1;
      end else if (bus_req.addr == TSC_OFS_CAP_ONE_LO) begin
        next_st.cap_inhibit[0] = 1'b0;
      end else if (bus_req.addr == TSC_OFS_CAP_TWO_HI) begin
        next_st.cap_inhibit[1] = 1'b1;
      end else if (bus_req.addr == TSC_OFS_CAP_TWO_LO) begin
        next_st.cap_inhibit[1] = 1'b0;
      end
    end

    // Read data stand for exactly the cycle after the strobe
    next_st.rdata = 8'h00;
    if (bus_req.rd) begin
      if (bus_req.addr == TSC_OFS_TIMER_FLAGS) begin
        next_st.rdata = flags_byte;
      end else if (bus_req.addr == TSC_OFS_CAP_ONE_HI) begin
        next_st.rdata = cap_one_value[15:8];
      end else if (bus_req.addr == TSC_OFS_CAP_ONE_LO) begin
        next_st.rdata = cap_one_value[7:0];
      end else if (bus_req.addr == TSC_OFS_CAP_TWO_HI) begin
        next_st.rdata = cap_two_value[15:8];
      end else if (bus_req.addr == TSC_OFS_CAP_TWO_LO) begin
        next_st.rdata = cap_two_value[7:0];
      end else if (bus_req.addr == TSC_OFS_CMP_ONE_HI) begin
        next_st.rdata = st.cmp_one[15:8];
      end else if (bus_req.addr == TSC_OFS_CMP_ONE_LO) begin
        next_st.rdata = st.cmp_one[7:0];
      end else if (bus_req.addr == TSC_OFS_CMP_TWO_HI) begin
        next_st.rdata = st.cmp_two[15:8];
      end else if (bus_req.addr == TSC_OFS_CMP_TWO_LO) begin
        next_st.rdata = st.cmp_two[7:0];
      end else if (bus_req.addr == TSC_OFS_COUNT_HI || bus_req.addr == TSC_OFS_ALT_HI) begin
        next_st.rdata = st.count[15:8];
      end else if (bus_req.addr == TSC_OFS_COUNT_LO || bus_req.addr == TSC_OFS_ALT_LO) begin
        next_st.rdata = st.count[7:0];
      end else if (bus_req.addr == TSC_OFS_CONTROL) begin
        next_st.rdata = st.control;
      end else if (bus_req.addr == TSC_OFS_EDGE) begin
        next_st.rdata = st.edges;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st         <= '0;
      st.count   <= TSC_COUNT_RESET;
      st.control <= TSC_CONTROL_RESET;
      st.edges   <= TSC_EDGE_RESET;
      st.cmp_one <= TSC_COMPARE_RESET;
      st.cmp_two <= TSC_COMPARE_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;

endmodule

// ---- dv/tsc_timer_status_asserts.sv ----
// Port-level property checker for the timer status block
`timescale 1ns/1ps
module tsc_timer_status_asserts #(
  parameter logic [7:0] PRESCALE = tsc_pkg::TSC_PRESCALE
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  nrst,
  // Register port
  input wire tsc_pkg::tsc_bus_req_t bus_req,
  input wire logic [7:0]            rdata,
  // Pins and power state
  input wire logic                  capture_input_pin_one,
  input wire logic                  capture_input_pin_two,
  input wire logic                  wait_mode,
  input wire logic                  stop_mode,
  input wire logic                  irq_enable,
  // Requests
  input wire logic                  timer_irq,
  input wire logic                  wait_wake
);
  import tsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ====================
  // Helper state
  logic       rd_q;
  logic       ctl_wr;
  logic       hold_v;
  logic       lo_rd;
  logic [3:0] stop_h;
  logic [7:0] addr_q;
  logic [7:0] hold_lo;
  assign lo_rd = rd_q && addr_q == TSC_OFS_COUNT_LO && (&stop_h) && stop_mode;
  always_ff @(posedge clk) begin
    rd_q   <= bus_req.rd;
    addr_q <= bus_req.addr;
    stop_h <= {stop_h[2:0], stop_mode};
    if (!nrst) ctl_wr <= 1'b0;
    else if (bus_req.wr && bus_req.addr == TSC_OFS_CONTROL) ctl_wr <= 1'b1;
    // Only a long-held stop gives a count worth remembering
    if (!nrst || !stop_mode) hold_v <= 1'b0;
    else if (lo_rd) hold_v <= 1'b1;
    if (lo_rd) hold_lo <= rdata;
  end
  // ====================
  // Properties
  bus_idle_zero_a: assert property (!rd_q |-> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  flags_bit0_a: assert property (rd_q && addr_q == TSC_OFS_TIMER_FLAGS |-> !rdata[0])
    else $error("flags bit 0 read as one");
  unmapped_zero_a: assert property (rd_q && addr_q == 8'h00 |-> rdata == 8'h00)
    else $error("unmapped read not zero");
  wake_gate_a: assert property (wait_wake == (timer_irq && irq_enable && wait_mode))
    else $error("wake request does not follow irq, enable and wait");
  irq_off_a: assert property (!ctl_wr |-> !timer_irq)
    else $error("timer request with all enables at reset value");
  irq_fall_a: assert property ($fell(timer_irq) |-> $past(bus_req.rd || bus_req.wr))
    else $error("timer request dropped without a register access");
  stop_hold_a: assert property (lo_rd && hold_v |-> rdata == hold_lo)
    else $error("counter moved during stop");
  stop_silent_a: assert property (
    (&stop_h) && stop_mode && !$past(bus_req.wr) |-> !$rose(timer_irq))
    else $error("timer request raised during stop");
  wake_c: cover property (wait_wake);
  hold_c: cover property (lo_rd && hold_v);
  fall_c: cover property ($fell(timer_irq));
endmodule

bind tsc_timer_status tsc_timer_status_asserts #(.PRESCALE(PRESCALE)) u_chk (
  .clk(clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
  .capture_input_pin_one(capture_input_pin_one),
  .capture_input_pin_two(capture_input_pin_two),
  .wait_mode(wait_mode), .stop_mode(stop_mode), .irq_enable(irq_enable),
  .timer_irq(timer_irq), .wait_wake(wait_wake)
);

// ---- dv/tsc_pin_model.sv ----
// Capture pin sources standing on the far side of the block
`timescale 1ns/1ps
module tsc_pin_model (
  // Clock
  input wire logic clk,
  // Pins
  output logic     pin_one,
  output logic     pin_two
);
  initial begin
    pin_one = 1'b1;
    pin_two = 1'b0;
  end
  // Pins are synchronous, so levels move just after an edge
  task automatic drive(input logic one, input logic two);
    @(posedge clk);
    pin_one <= one;
    pin_two <= two;
  endtask
endmodule

// ---- dv/testbench.sv ----
// Self-checking bench for the timer status block
`timescale 1ns/1ps
module testbench;
  import tsc_pkg::*;
  // ====================
  // Signals
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  tsc_bus_req_t bus_req = '0;
  logic [7:0]   rdata;
  logic         pin_one;
  logic         pin_two;
  logic         wait_mode = 1'b0;
  logic         stop_mode = 1'b0;
  logic         irq_enable = 1'b0;
  logic         timer_irq;
  logic         wait_wake;
  int           bad_count = 0;
  int           cmp_count = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  // Prescale of one keeps rollover four clocks after reset
  tsc_timer_status #(.PRESCALE(8'h01)) u_dut (
    .clk(clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata),
    .capture_input_pin_one(pin_one), .capture_input_pin_two(pin_two),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .irq_enable(irq_enable),
    .timer_irq(timer_irq), .wait_wake(wait_wake)
  );
  tsc_pin_model u_pins (.clk(clk), .pin_one(pin_one), .pin_two(pin_two));

  // ====================
  // Tasks
  task automatic give_verdict();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic check8(input logic [7:0] got, input logic [7:0] want);
    cmp_count++;
    if (got !== want) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] d;
    bus_rd(a, d);
    check8(d, want);
  endtask
  task automatic irq_chk(input logic [1:0] want);
    @(negedge clk);
    check8({6'h00, timer_irq, wait_wake}, {6'h00, want});
  endtask

  // ====================
  // Tests
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] ch;
    logic [7:0] cl;
    idle(6);
    nrst <= 1'b1;
    idle(10);
    // Rollover and both compares hit at zero with pin one high
    chk(TSC_OFS_TIMER_FLAGS, 8'h3C);
    bus_wr(TSC_OFS_TIMER_FLAGS, 8'hFF);
    chk(TSC_OFS_TIMER_FLAGS, 8'h3C);
    chk(8'h00, 8'h00);
    bus_rd(TSC_OFS_ALT_LO, a);
    chk(TSC_OFS_TIMER_FLAGS, 8'h3C);
    bus_rd(TSC_OFS_COUNT_LO, a);
    chk(TSC_OFS_TIMER_FLAGS, 8'h2C);
    bus_rd(TSC_OFS_CMP_ONE_LO, a);
    chk(TSC_OFS_TIMER_FLAGS, 8'h0C);
    bus_rd(TSC_OFS_CMP_TWO_LO, a);
    chk(TSC_OFS_TIMER_FLAGS, 8'h04);
    // Wrong polarity first, then the chosen one on both pins
    bus_wr(TSC_OFS_EDGE, 8'h02);
    u_pins.drive(1'b0, 1'b1);
    idle(4);
    chk(TSC_OFS_TIMER_FLAGS, 8'h04);
    u_pins.drive(1'b1, 1'b0);
    idle(4);
    // Capture flags were clear at the last status read, so not armed
    bus_rd(TSC_OFS_CAP_ONE_LO, a);
    chk(TSC_OFS_TIMER_FLAGS, 8'hC4);
    bus_rd(TSC_OFS_CAP_ONE_LO, a);
    bus_rd(TSC_OFS_CAP_TWO_LO, a);
    chk(TSC_OFS_TIMER_FLAGS, 8'h04);
    // Stop: frozen count, silent capture, flag on wake
    idle(1);
    stop_mode <= 1'b1;
    idle(4);
    bus_rd(TSC_OFS_COUNT_HI, ch);
    bus_rd(TSC_OFS_COUNT_LO, cl);
    idle(5);
    chk(TSC_OFS_COUNT_LO, cl);
    u_pins.drive(1'b0, 1'b0);
    u_pins.drive(1'b1, 1'b0);
    idle(4);
    chk(TSC_OFS_TIMER_FLAGS, 8'h04);
    idle(1);
    stop_mode <= 1'b0;
    idle(4);
    chk(TSC_OFS_TIMER_FLAGS, 8'h84);
    chk(TSC_OFS_CAP_ONE_HI, ch);
    chk(TSC_OFS_CAP_ONE_LO, cl);
    // Reset in stop drops the armed capture; pin two left high
    idle(1);
    stop_mode <= 1'b1;
    u_pins.drive(1'b0, 1'b0);
    u_pins.drive(1'b1, 1'b1);
    idle(4);
    nrst <= 1'b0;
    idle(6);
    nrst <= 1'b1;
    chk(TSC_OFS_COUNT_HI, 8'hFF);
    chk(TSC_OFS_COUNT_LO, 8'hFC);
    chk(TSC_OFS_CAP_ONE_LO, 8'h00);
    idle(1);
    stop_mode <= 1'b0;
    idle(8);
    chk(TSC_OFS_TIMER_FLAGS, 8'h3E);
    // Capture request gated by its enable, wake gated by interrupts
    bus_wr(TSC_OFS_CONTROL, 8'h80);
    irq_chk(2'b00);
    u_pins.drive(1'b0, 1'b0);
    wait_mode <= 1'b1;
    idle(4);
    irq_chk(2'b10);
    idle(1);
    irq_enable <= 1'b1;
    irq_chk(2'b11);
    bus_rd(TSC_OFS_ALT_LO, a);
    bus_rd(TSC_OFS_ALT_LO, b);
    check8(b, a + 8'h02);
    bus_wr(TSC_OFS_CONTROL, 8'h01);
    irq_chk(2'b00);
    bus_rd(TSC_OFS_ALT_LO, a);
    bus_rd(TSC_OFS_ALT_LO, b);
    check8(b, a);
    bus_wr(TSC_OFS_CONTROL, 8'h00);
    bus_rd(TSC_OFS_ALT_LO, a);
    bus_rd(TSC_OFS_ALT_LO, b);
    check8(b, a + 8'h02);
    give_verdict();
  end

  // Tests need some 160 clocks; a hang is cut well beyond that
  initial begin
    idle(2000);
    bad_count++;
    give_verdict();
  end
endmodule
